// File: rtl/internal_clock_generator.sv
`timescale 1ns/1ps
// What this block does
// - bypassed external outputs the external reference while its loop drives the link clock.
// - external low-power bypass stops loop and link, output from the external reference.
// - the external reference may be the controlled crystal oscillator or any other clock.
// - stop disables the loop and both clocks, references stay on only with both their out and stop enables set.
// - no signal of the block leaves the chip.
// - engaged internal: output from loop on divided internal reference, link clock on.
// - engaged external: output from loop on divided external reference, link clock on.
// - select 01, internal reference, debug or low power clear give bypassed internal.
// - bypassed internal outputs the internal reference while loop and link keep running.
// - select 01, internal reference, no debug and low power set give internal low power.
// - internal low-power bypass stops loop and link, output from the internal reference.
module internal_clock_generator
    import clkgen_pkg::*;
#(
    parameter int DIV_W = 3
) (
    input wire logic SYS_CLK,
    input wire logic SYS_RST,
    input wire logic CLK_EN,
    // register port
    input wire logic [1:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    // on-chip clock sources as enable ticks on SYS_CLK
    input wire logic INT_REF_TICK,
    input wire logic EXT_REF_TICK,
    input wire logic OSC_READY,
    // chip state
    input wire logic DEBUG_ACTIVE,
    input wire logic STOP_REQ,
    // clock outputs as enable ticks and status
    output logic GEN_OUT_TICK,
    output logic LINK_TICK,
    output logic LOOP_ENABLE,
    output logic INT_REF_ON,
    output logic EXT_REF_ON,
    output logic OSC_ENABLE,
    output logic HIGH_GAIN,
    output logic [1:0] BUS_DIV,
    output logic [7:0] TRIM_OUT
);
    // refused at elaboration: the divider field width is fixed by the register
    if (DIV_W != REFDIV_MSB - REFDIV_LSB + 1) begin : g_bad_div
        $error("DIV_W must match divider field");
    end

    typedef struct packed {
        ctrl_type ctrl;
        gen_mode_type mode;
        logic [1:0] src_status;
        logic int_status;
        logic [3:0] settle;
        logic [7:0] rdata;
        logic out_tick;
        logic link_tick;
        logic osc_rdy_m;
        logic osc_rdy_s;
        logic osc_init;
        logic dbg_m;
        logic dbg_s;
        logic stop_m;
        logic stop_s;
    } gen_state_type;

    gen_state_type s_q;
    gen_state_type s_d;
    route_type route;
    logic [1:0] clk_sel;
    logic [DIV_W-1:0] ref_div;
    logic int_sel;
    logic low_power;
    logic ref_tick;
    logic div_tick;
    logic loop_tick;
    logic loop_locked;
    gen_mode_type mode_req;

    // mode decode from control fields and debug state
    function automatic gen_mode_type decode_mode(
        input logic [1:0] sel,
        input logic int_ref,
        input logic lp,
        input logic dbg,
        input logic stop
    );
        gen_mode_type m;
        m = ST_ENGAGED_INT;
        if (stop) begin
            m = ST_STOP;
        end else begin
            case (sel)
                CLKSEL_LOOP: m = int_ref ? ST_ENGAGED_INT : ST_ENGAGED_EXT;
                CLKSEL_INTREF: begin
                    m = (dbg || !lp) ? ST_BYPASS_INT : ST_BYPASS_INT_LP;
                end
                CLKSEL_EXTREF: m = (dbg || !lp) ? ST_BYPASS_EXT : ST_BYPASS_EXT_LP;
                default: m = int_ref ? ST_ENGAGED_INT : ST_ENGAGED_EXT; // reserved code acts as 00
            endcase
        end
        return m;
    endfunction : decode_mode

    assign clk_sel = s_q.ctrl.mode_ctrl[CLKSEL_MSB:CLKSEL_LSB];
    assign ref_div = s_q.ctrl.mode_ctrl[REFDIV_MSB:REFDIV_LSB];
    assign int_sel = s_q.ctrl.mode_ctrl[INTREF_SEL_POS];
    assign low_power = s_q.ctrl.osc_ctrl[LOW_POWER_POS];
    assign mode_req = decode_mode(clk_sel, int_sel, low_power, s_q.dbg_s, s_q.stop_s);

    // routing per mode
    always_comb begin
        route = '0;
        case (s_q.mode)
            ST_ENGAGED_INT: begin
                route.loop_enable = 1'b1;
                route.out_from_loop = 1'b1;
                route.link_enable = 1'b1;
                route.int_ref_on = 1'b1;
            end
            ST_ENGAGED_EXT: begin
                route.loop_enable = 1'b1;
                route.out_from_loop = 1'b1;
                route.link_enable = 1'b1;
                route.ext_ref_on = 1'b1;
            end
            ST_BYPASS_INT: begin
                route.loop_enable = 1'b1;
                route.out_from_int = 1'b1;
                route.link_enable = 1'b1;
                route.int_ref_on = 1'b1;
            end
            ST_BYPASS_INT_LP: begin
                route.out_from_int = 1'b1;
                route.int_ref_on = 1'b1;
            end
            ST_BYPASS_EXT: begin
                route.loop_enable = 1'b1;
                route.out_from_ext = 1'b1;
                route.link_enable = 1'b1;
                route.ext_ref_on = 1'b1;
            end
            ST_BYPASS_EXT_LP: begin
                route.out_from_ext = 1'b1;
                route.ext_ref_on = 1'b1;
            end
            ST_STOP: begin
                // references stay on only with both their out and stop enables set
                route.int_ref_on = s_q.ctrl.mode_ctrl[INTREF_OUT_EN_POS]
                    && s_q.ctrl.mode_ctrl[INTREF_STOP_EN_POS];
                route.ext_ref_on = s_q.ctrl.osc_ctrl[EXTREF_OUT_EN_POS]
                    && s_q.ctrl.osc_ctrl[EXTREF_STOP_EN_POS];
            end
            default: route = '0;
        endcase
        // out-enables keep a reference running outside stop too
        if (s_q.mode != ST_STOP) begin
            route.int_ref_on = route.int_ref_on || s_q.ctrl.mode_ctrl[INTREF_OUT_EN_POS];
            route.ext_ref_on = route.ext_ref_on || s_q.ctrl.osc_ctrl[EXTREF_OUT_EN_POS];
        end
    end

    // loop reference follows the reference select bit
    assign ref_tick = int_sel ? INT_REF_TICK : EXT_REF_TICK;

    clk_divider #(
        .SEL_W(DIV_W)
    ) u_ref_div (
        .clk(SYS_CLK),
        .rst(SYS_RST),
        .ce(CLK_EN),
        .tick_in(ref_tick),
        .sel(ref_div),
        .tick_out(div_tick)
    );

    freq_locked_loop #(
        .MULT(LOOP_MULT)
    ) u_loop (
        .clk(SYS_CLK),
        .rst(SYS_RST),
        .ce(CLK_EN),
        .enable(route.loop_enable),
        .ref_tick(div_tick),
        .out_tick(loop_tick),
        .locked(loop_locked)
    );

    // registers, synchronisers, mode tracking and outputs
    always_comb begin
        s_d = s_q;
        s_d.rdata = 8'h00;
        // pin-like inputs from other domains, two flops each
        s_d.osc_rdy_m = OSC_READY;
        s_d.osc_rdy_s = s_q.osc_rdy_m;
        s_d.dbg_m = DEBUG_ACTIVE;
        s_d.dbg_s = s_q.dbg_m;
        s_d.stop_m = STOP_REQ;
        s_d.stop_s = s_q.stop_m;
        // oscillator ready only counts while external crystal is chosen
        s_d.osc_init = s_q.osc_rdy_s && s_q.ctrl.osc_ctrl[EXTREF_SEL_POS];
        if (WR) begin
            case (ADDR)
                ADDR_MODE_CTRL: s_d.ctrl.mode_ctrl = WDATA;
                ADDR_OSC_CTRL: s_d.ctrl.osc_ctrl = WDATA;
                ADDR_TRIM_VALUE: s_d.ctrl.trim_value = WDATA;
                ADDR_STATE_REPORT: s_d.ctrl.fine_trim = WDATA[FINE_TRIM_POS];
                default: s_d.ctrl = s_q.ctrl;
            endcase
        end
        if (RD) begin
            case (ADDR)
                ADDR_MODE_CTRL: s_d.rdata = s_q.ctrl.mode_ctrl;
                ADDR_OSC_CTRL: s_d.rdata = s_q.ctrl.osc_ctrl;
                ADDR_TRIM_VALUE: s_d.rdata = s_q.ctrl.trim_value;
                ADDR_STATE_REPORT: begin
                    s_d.rdata[INTREF_STATUS_POS] = s_q.int_status;
                    s_d.rdata[SRC_STATUS_MSB:SRC_STATUS_LSB] = s_q.src_status;
                    s_d.rdata[OSC_INIT_POS] = s_q.osc_init;
                    s_d.rdata[FINE_TRIM_POS] = s_q.ctrl.fine_trim;
                end
                default: s_d.rdata = 8'h00;
            endcase
        end
        // status follows the request after a short settle, so software can poll
        if (mode_req != s_q.mode) begin
            s_d.mode = mode_req;
            s_d.settle = SWITCH_CYCLES;
        end else if (s_q.settle != 4'h0) begin
            s_d.settle = s_q.settle - 4'h1;
        end else if (s_q.mode != ST_STOP) begin
            s_d.src_status = (s_q.mode inside {ST_ENGAGED_INT, ST_ENGAGED_EXT})
                ? (loop_locked ? CLKSEL_LOOP : s_q.src_status)
                : ((s_q.mode inside {ST_BYPASS_INT, ST_BYPASS_INT_LP})
                   ? CLKSEL_INTREF : CLKSEL_EXTREF);
            s_d.int_status = int_sel;
        end
        // clock ticks; stop gives none at all
        s_d.out_tick = (route.out_from_loop && loop_tick)
            || (route.out_from_int && INT_REF_TICK)
            || (route.out_from_ext && EXT_REF_TICK);
        s_d.link_tick = route.link_enable && loop_tick;
    end

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            s_q <= '0;
            s_q.ctrl.mode_ctrl <= MODE_CTRL_RESET;
            s_q.ctrl.osc_ctrl <= OSC_CTRL_RESET;
            s_q.ctrl.trim_value <= TRIM_VALUE_RESET;
            s_q.mode <= ST_ENGAGED_INT;
            s_q.int_status <= 1'b1;
        end else if (CLK_EN) begin
            s_q <= s_d;
        end
    end

    // all outputs are on-chip nets only
    assign RDATA = s_q.rdata;
    assign GEN_OUT_TICK = s_q.out_tick;
    assign LINK_TICK = s_q.link_tick;
    assign LOOP_ENABLE = route.loop_enable;
    assign INT_REF_ON = route.int_ref_on;
    assign EXT_REF_ON = route.ext_ref_on;
    assign OSC_ENABLE = route.ext_ref_on && s_q.ctrl.osc_ctrl[EXTREF_SEL_POS];
    assign HIGH_GAIN = s_q.ctrl.osc_ctrl[HIGH_GAIN_POS];
    assign BUS_DIV = s_q.ctrl.osc_ctrl[BUSDIV_MSB:BUSDIV_LSB];
    assign TRIM_OUT = s_q.ctrl.trim_value;
endmodule : internal_clock_generator

// File: pkg/clkgen_pkg.sv
package clkgen_pkg;

    // register indices on the plain port (byte wide registers)
    localparam logic [1:0] ADDR_MODE_CTRL = 2'h0;
    localparam logic [1:0] ADDR_OSC_CTRL = 2'h1;
    localparam logic [1:0] ADDR_TRIM_VALUE = 2'h2;
    localparam logic [1:0] ADDR_STATE_REPORT = 2'h3;

    // reset values of the writable registers
    localparam logic [7:0] MODE_CTRL_RESET = 8'h04;
    localparam logic [7:0] OSC_CTRL_RESET = 8'h40;
    localparam logic [7:0] TRIM_VALUE_RESET = 8'h80;

    // field positions in clock_mode_ctrl
    localparam int CLKSEL_MSB = 7;
    localparam int CLKSEL_LSB = 6;
    localparam int REFDIV_MSB = 5;
    localparam int REFDIV_LSB = 3;
    localparam int INTREF_SEL_POS = 2;
    localparam int INTREF_OUT_EN_POS = 1;
    localparam int INTREF_STOP_EN_POS = 0;

    // field positions in clock_osc_ctrl
    localparam int BUSDIV_MSB = 7;
    localparam int BUSDIV_LSB = 6;
    localparam int RANGE_POS = 5;
    localparam int HIGH_GAIN_POS = 4;
    localparam int LOW_POWER_POS = 3;
    localparam int EXTREF_SEL_POS = 2;
    localparam int EXTREF_OUT_EN_POS = 1;
    localparam int EXTREF_STOP_EN_POS = 0;

    // field positions in clock_state_report
    localparam int INTREF_STATUS_POS = 4;
    localparam int SRC_STATUS_MSB = 3;
    localparam int SRC_STATUS_LSB = 2;
    localparam int OSC_INIT_POS = 1;
    localparam int FINE_TRIM_POS = 0;

    // clock select field codes
    localparam logic [1:0] CLKSEL_LOOP = 2'h0;
    localparam logic [1:0] CLKSEL_INTREF = 2'h1;
    localparam logic [1:0] CLKSEL_EXTREF = 2'h2;

    // loop multiplication factor
    localparam int LOOP_MULT = 1024;
    // cycles of settling before the source status follows a request
    localparam logic [3:0] SWITCH_CYCLES = 4'h4;
    // oscillator start-up cycles; not used, ready is reported from the synchronised OSC_READY
    localparam logic [7:0] OSC_START_CYCLES = 8'h40;

    typedef enum logic [6:0] {
        ST_ENGAGED_INT = 7'h01,
        ST_ENGAGED_EXT = 7'h02,
        ST_BYPASS_INT = 7'h04,
        ST_BYPASS_INT_LP = 7'h08,
        ST_BYPASS_EXT = 7'h10,
        ST_BYPASS_EXT_LP = 7'h20,
        ST_STOP = 7'h40
    } gen_mode_type;

    // per-mode clock routing decision
    typedef struct packed {
        logic loop_enable;
        logic out_from_loop;
        logic out_from_int;
        logic out_from_ext;
        logic link_enable;
        logic int_ref_on;
        logic ext_ref_on;
    } route_type;

    // software visible control registers
    typedef struct packed {
        logic [7:0] mode_ctrl;
        logic [7:0] osc_ctrl;
        logic [7:0] trim_value;
        logic fine_trim;
    } ctrl_type;

endpackage : clkgen_pkg

// File: rtl/clk_divider.sv
`timescale 1ns/1ps
// divides an enabled reference edge stream by 2**sel
module clk_divider
    import clkgen_pkg::*;
#(
    parameter int SEL_W = 3
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic tick_in,
    input wire logic [SEL_W-1:0] sel,
    output logic tick_out
);
    // refused at elaboration: the terminal count is built in 16 bits
    if (SEL_W < 1 || SEL_W > 4) begin : g_bad_sel
        $error("clk_divider: SEL_W out of range");
    end

    typedef struct packed {
        logic [15:0] count;
        logic tick;
    } div_state_type;

    div_state_type s_q;
    div_state_type s_d;

    // terminal count derived from the select value
    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (tick_in) begin
            if (s_q.count >= ((16'h0001 << sel) - 16'h0001)) begin
                s_d.count = 16'h0000;
                s_d.tick = 1'b1;
            end else begin
                s_d.count = s_q.count + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign tick_out = s_q.tick;
endmodule : clk_divider

// File: rtl/freq_locked_loop.sv
`timescale 1ns/1ps
// behavioural loop: emits up to MULT output ticks per reference tick, one per cycle at most, once a period is measured
module freq_locked_loop
    import clkgen_pkg::*;
#(
    parameter int MULT = LOOP_MULT
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic enable,
    input wire logic ref_tick,
    output logic out_tick,
    output logic locked
);
    // refused at elaboration: the phase step must fit 16 bits
    if (MULT < 2 || MULT > 65535) begin : g_bad_mult
        $error("freq_locked_loop: MULT out of range");
    end

    typedef struct packed {
        logic [15:0] period;
        logic [15:0] since_ref;
        logic [15:0] phase;
        logic tick;
        logic lock;
    } loop_state_type;

    loop_state_type s_q;
    loop_state_type s_d;

    // measure the reference period in system cycles, then spread ticks over it;
    // a simple stand-in for the analog loop, good enough for mode steering
    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (!enable) begin
            s_d = '0;
        end else begin
            s_d.since_ref = s_q.since_ref + 16'h0001;
            s_d.phase = s_q.phase + 16'(MULT);
            if (s_q.phase >= s_q.period && s_q.period != 16'h0000) begin
                s_d.phase = s_q.phase - s_q.period + 16'(MULT);
                s_d.tick = 1'b1;
            end
            if (ref_tick) begin
                s_d.period = s_q.since_ref + 16'h0001;
                s_d.since_ref = 16'h0000;
                s_d.lock = (s_q.period != 16'h0000);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign out_tick = s_q.tick;
    assign locked = s_q.lock;
endmodule : freq_locked_loop

// File: tb/clkgen_chk.sv
`timescale 1ns/1ps
// port checker; keeps its own copy of the two control bytes
module clkgen_chk
    import clkgen_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic SYS_RST,
    input wire logic [1:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    input wire logic INT_REF_TICK,
    input wire logic EXT_REF_TICK,
    input wire logic DEBUG_ACTIVE,
    input wire logic STOP_REQ,
    input wire logic GEN_OUT_TICK,
    input wire logic LINK_TICK,
    input wire logic LOOP_ENABLE,
    input wire logic INT_REF_ON,
    input wire logic EXT_REF_ON
);
    logic [7:0] mode_q, osc_q;
    logic [4:0] calm_q;
    logic dbg_q, stop_q, calm, eng, int_ref_select, byp_int, byp_ext, loop_exp;
    logic [1:0] sel;

    // shadow registers; calm counts quiet cycles so sync delays are over
    always_ff @(posedge SYS_CLK) begin
        dbg_q <= DEBUG_ACTIVE;
        stop_q <= STOP_REQ;
        if (SYS_RST) begin
            mode_q <= MODE_CTRL_RESET;
            osc_q <= OSC_CTRL_RESET;
            calm_q <= 5'h0;
        end else begin
            if (WR && ADDR == ADDR_MODE_CTRL) mode_q <= WDATA;
            if (WR && ADDR == ADDR_OSC_CTRL) osc_q <= WDATA;
            if (WR || DEBUG_ACTIVE != dbg_q || STOP_REQ != stop_q) calm_q <= 5'h0;
            else if (calm_q != 5'h1f) calm_q <= calm_q + 5'h1;
        end
    end

    // expected routing from the shadow copy
    assign sel = mode_q[CLKSEL_MSB:CLKSEL_LSB];
    assign int_ref_select = mode_q[INTREF_SEL_POS];
    // the edge that sees an input change is not calm yet
    assign calm = calm_q >= 5'h14 && DEBUG_ACTIVE == dbg_q && STOP_REQ == stop_q;
    assign eng = sel == CLKSEL_LOOP || sel == 2'h3;
    assign loop_exp = eng || !(osc_q[LOW_POWER_POS] && !DEBUG_ACTIVE);
    assign byp_int = calm && !STOP_REQ && sel == CLKSEL_INTREF && int_ref_select;
    assign byp_ext = calm && !STOP_REQ && sel == CLKSEL_EXTREF;

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST);

    a_stop_quiet: assert property (STOP_REQ [*6]
        |-> !GEN_OUT_TICK && !LINK_TICK && !LOOP_ENABLE)
        else $error("clock activity in stop");
    a_stop_refs: assert property (calm && STOP_REQ
        |-> INT_REF_ON == (mode_q[1] && mode_q[0]) && EXT_REF_ON == (osc_q[1] && osc_q[0]))
        else $error("reference enable wrong in stop");
    a_lowpow_link: assert property (!LOOP_ENABLE [*4] |-> !LINK_TICK)
        else $error("link tick with loop off");
    a_loop_mode: assert property (calm && !STOP_REQ
        |-> LOOP_ENABLE == loop_exp)
        else $error("loop enable wrong for mode");
    a_int_follow: assert property (byp_int && INT_REF_TICK |-> ##[1:3] GEN_OUT_TICK)
        else $error("internal bypass tick missing");
    a_int_only: assert property (byp_int && GEN_OUT_TICK
        |-> $past(INT_REF_TICK) || $past(INT_REF_TICK, 2) || $past(INT_REF_TICK, 3))
        else $error("output tick without internal tick");
    a_ext_follow: assert property (byp_ext && EXT_REF_TICK
        |-> ##[1:3] GEN_OUT_TICK)
        else $error("external bypass tick missing");
    a_int_on: assert property (calm && !STOP_REQ && (sel == 2'h1 || (eng && int_ref_select))
        |-> INT_REF_ON)
        else $error("internal reference off");
    a_ext_on: assert property (calm && !STOP_REQ && (sel == 2'h2 || (eng && !int_ref_select))
        |-> EXT_REF_ON)
        else $error("external reference off");
    a_state_zero: assert property (RD && ADDR == ADDR_STATE_REPORT
        |=> RDATA[7:5] == 3'h0)
        else $error("reserved status bits set");

    c_int_byp: cover property (byp_int && GEN_OUT_TICK);
    c_ext_byp: cover property (byp_ext && GEN_OUT_TICK);
    c_stop: cover property (calm && STOP_REQ);
endmodule : clkgen_chk

bind internal_clock_generator clkgen_chk u_chk (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .INT_REF_TICK(INT_REF_TICK),
    .EXT_REF_TICK(EXT_REF_TICK), .DEBUG_ACTIVE(DEBUG_ACTIVE), .STOP_REQ(STOP_REQ),
    .GEN_OUT_TICK(GEN_OUT_TICK), .LINK_TICK(LINK_TICK), .LOOP_ENABLE(LOOP_ENABLE),
    .INT_REF_ON(INT_REF_ON), .EXT_REF_ON(EXT_REF_ON));

// File: tb/clock_consumer.sv
`timescale 1ns/1ps
// cpu, bus and debug side: counts the ticks it is handed
module clock_consumer (
    input wire logic clk,
    input wire logic clear,
    input wire logic gen_tick,
    input wire logic link_tick,
    output logic [7:0] gen_count,
    output logic [7:0] link_count
);
    // counts reset to zero while clear is high, so a window is exact
    always_ff @(posedge clk) begin
        if (clear) begin
            gen_count <= 8'h0;
            link_count <= 8'h0;
        end else begin
            gen_count <= gen_count + {7'h0, gen_tick};
            link_count <= link_count + {7'h0, link_tick};
        end
    end
endmodule : clock_consumer

// File: tb/tb_internal_clock_generator.sv
`timescale 1ns/1ps
// register-level tests of mode routing and stop behaviour
module tb_internal_clock_generator
    import clkgen_pkg::*;
;
    logic sys_clk, sys_rst, clk_en, wr, rd, osc_ready, debug_active, stop_req, clear;
    logic int_ref_tick, ext_ref_tick, gen_out_tick, link_tick, loop_enable;
    logic int_ref_on, ext_ref_on, high_gain, osc_enable;
    logic [1:0] addr, bus_div;
    logic [7:0] wdata, rdata, trim_out, v, gen_count, link_count;
    logic [15:0] phase = 16'h0;
    int num_errors, comparisons;

    internal_clock_generator u_dut (.SYS_CLK(sys_clk), .SYS_RST(sys_rst), .CLK_EN(clk_en),
        .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .INT_REF_TICK(int_ref_tick), .EXT_REF_TICK(ext_ref_tick), .OSC_READY(osc_ready),
        .DEBUG_ACTIVE(debug_active), .STOP_REQ(stop_req), .GEN_OUT_TICK(gen_out_tick),
        .LINK_TICK(link_tick), .LOOP_ENABLE(loop_enable), .INT_REF_ON(int_ref_on),
        .EXT_REF_ON(ext_ref_on), .OSC_ENABLE(osc_enable), .HIGH_GAIN(high_gain), .BUS_DIV(bus_div),
        .TRIM_OUT(trim_out));
    clock_consumer u_far (.clk(sys_clk), .clear(clear), .gen_tick(gen_out_tick),
        .link_tick(link_tick), .gen_count(gen_count), .link_count(link_count));

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // periods 8 and 6 both divide the 96-cycle window, so counts are exact
    always @(posedge sys_clk) begin
        phase <= phase + 16'h1;
        int_ref_tick <= phase[2:0] == 3'h0;
        ext_ref_tick <= phase % 16'h6 == 16'h0;
    end

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
            num_errors++;
        end
    endtask : check

    task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask : reg_write

    // read data stand only in the cycle after the strobe
    task automatic reg_read(input logic [1:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : reg_read

    task automatic measure(input logic [7:0] exp_gen, input logic link_off);
        @(posedge sys_clk);
        clear <= 1'b1;
        @(posedge sys_clk);
        clear <= 1'b0;
        repeat (96) @(posedge sys_clk);
        #1 if (exp_gen != 8'hff) check("gen ticks", exp_gen, gen_count);
        if (link_off) check("link ticks", 8'h0, link_count);
        else check("link present", 8'h1, {7'h0, link_count != 8'h0});
        clear <= 1'b1;
    endtask : measure

    task automatic run_mode(input string name, input logic [7:0] mode, input logic [7:0] osc,
        input logic dbg, input logic exp_loop, input logic [7:0] exp_gen);
        logic [2:0] got;
        got = 3'bxxx;
        reg_write(ADDR_MODE_CTRL, mode);
        reg_write(ADDR_OSC_CTRL, osc);
        debug_active <= dbg;
        repeat (20) @(posedge sys_clk);
        #1 check("loop enable", {7'h0, exp_loop}, {7'h0, loop_enable});
        if (mode[2]) check("int ref on", 8'h1, {7'h0, int_ref_on});
        if (!mode[2]) check("ext ref on", 8'h1, {7'h0, ext_ref_on});
        // status catches up after the switch delay, so poll it
        for (int i = 0; i < 100 && got !== {mode[2], mode[7:6]}; i++) begin
            reg_read(ADDR_STATE_REPORT, v);
            got = v[4:2];
        end
        check("state report", {5'h0, mode[2], mode[7:6]}, {5'h0, got});
        measure(exp_gen, !exp_loop);
        $display("test %s done", name);
    endtask : run_mode

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (30000) @(posedge sys_clk);
        num_errors++;
        $display("watchdog expired");
        report_and_stop();
    end

    initial begin
        {sys_rst, clk_en, clear} = 3'h7;
        {wr, rd, osc_ready, debug_active, stop_req} = 5'h0;
        {addr, wdata} = '0;
        repeat (12) @(posedge sys_clk);
        sys_rst <= 1'b0;
        reg_read(ADDR_MODE_CTRL, v);
        check("mode ctrl reset", MODE_CTRL_RESET, v);
        reg_read(ADDR_OSC_CTRL, v);
        check("osc ctrl reset", OSC_CTRL_RESET, v);
        reg_read(ADDR_TRIM_VALUE, v);
        check("trim reset", TRIM_VALUE_RESET, v);
        reg_read(ADDR_STATE_REPORT, v);
        check("state reset", 8'h10, v & 8'hfe);
        reg_write(ADDR_TRIM_VALUE, 8'h5a);
        reg_read(ADDR_TRIM_VALUE, v);
        check("trim read", 8'h5a, v);
        check("trim out", 8'h5a, trim_out);
        // a write while the block is frozen must not land
        @(posedge sys_clk) clk_en <= 1'b0;
        reg_write(ADDR_TRIM_VALUE, 8'h33);
        clk_en <= 1'b1;
        reg_read(ADDR_TRIM_VALUE, v);
        check("trim frozen", 8'h5a, v);
        reg_write(ADDR_OSC_CTRL, 8'hd0);
        #1 check("gain and divider", 8'h07, {5'h0, high_gain, bus_div});
        reg_write(ADDR_STATE_REPORT, 8'hff);
        reg_read(ADDR_STATE_REPORT, v);
        check("state write", 8'h01, v & 8'he1);
        $display("test registers done");
        run_mode("bypass int", 8'h46, 8'h00, 1'b0, 1'b1, 8'h0c);
        run_mode("bypass int debug", 8'h46, 8'h08, 1'b1, 1'b1, 8'h0c);
        run_mode("bypass int lowpower", 8'h46, 8'h08, 1'b0, 1'b0, 8'h0c);
        run_mode("bypass ext clock", 8'h82, 8'h02, 1'b0, 1'b1, 8'h10);
        @(posedge sys_clk) osc_ready <= 1'b1;
        run_mode("bypass ext crystal", 8'h82, 8'h06, 1'b0, 1'b1, 8'h10);
        reg_read(ADDR_STATE_REPORT, v);
        check("osc init", 8'h02, v & 8'h02);
        check("osc enable", 8'h1, {7'h0, osc_enable});
        run_mode("bypass ext lowpower", 8'h82, 8'h0a, 1'b0, 1'b0, 8'h10);
        run_mode("engaged ext", 8'h02, 8'h02, 1'b0, 1'b1, 8'hff);
        run_mode("engaged int", 8'h06, 8'h00, 1'b0, 1'b1, 8'hff);
        // stop keeps only the references whose stop enables are set
        reg_write(ADDR_MODE_CTRL, 8'h47);
        reg_write(ADDR_OSC_CTRL, 8'h02);
        stop_req <= 1'b1;
        repeat (20) @(posedge sys_clk);
        #1 check("stop loop", 8'h0, {7'h0, loop_enable});
        check("stop refs", 8'h2, {6'h0, int_ref_on, ext_ref_on});
        measure(8'h00, 1'b1);
        reg_write(ADDR_MODE_CTRL, 8'h46);
        reg_write(ADDR_OSC_CTRL, 8'h03);
        repeat (20) @(posedge sys_clk);
        #1 check("stop refs swapped", 8'h1, {6'h0, int_ref_on, ext_ref_on});
        stop_req <= 1'b0;
        $display("test stop done");
        report_and_stop();
    end
endmodule : tb_internal_clock_generator
